/* hw/cmd_edge_detect.sv */
// rising edge detector over successive effective command words
`timescale 1ns/10ps
`default_nettype none

module cmd_edge_detect #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             sample,
    input  wire logic [WIDTH-1:0] word,
    input  wire logic [WIDTH-1:0] reset_word,
    output logic      [WIDTH-1:0] rise
);

    // ========================================================
    // previous word and edge pulses
    logic [WIDTH-1:0] prev_word;
    logic             prev_loaded;

    // refuse a width the word logic cannot serve
    if (WIDTH < 1) begin : g_bad_width
        $error("cmd_edge_detect: WIDTH must be at least 1");
    end

    // previous word is loaded with each sampled word; the reset word stands in for it until the first sample
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_word   <= '0;
            prev_loaded <= 1'b0;
        end else if (sample) begin
            prev_word   <= word;
            prev_loaded <= 1'b1;
        end
    end

    // one-cycle pulse per bit going low to high between samples
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rise <= '0;
        end else if (sample) begin
            rise <= word & ~(prev_loaded ? prev_word : reset_word);
        end else begin
            rise <= '0;
        end
    end

endmodule : cmd_edge_detect

`default_nettype wire

/* hw/cmd_word_consts.svh */
// constants for the fieldbus command word decoder
`ifndef CMD_WORD_CONSTS_SVH
`define CMD_WORD_CONSTS_SVH

// ========================================================
// command word field positions
`define CMD_BIT_SWITCH_ON    0
`define CMD_BIT_BREAKER_EN   1
`define CMD_BIT_QUICK_STOP   2
`define CMD_BIT_START        3
`define CMD_BIT_PRECHARGE    4
`define CMD_BIT_EVENT_CLEAR  7
`define CMD_BIT_VALID        10
`define CMD_BIT_WATCHDOG     11
`define CMD_AUX_LSB          12
`define CMD_AUX_MSB          15

// ========================================================
// reset and default values
`define CMD_WORD_WIDTH       16
`define CMD_DEFAULT_WORD     16'h0005
`define CMD_USED_MASK        16'hFC9F

`endif

/* hw/cmd_word_pkg.sv */
// types for the fieldbus command word decoder
package cmd_word_pkg;

    // ========================================================
    // start sequencing state
    typedef enum logic [1:0] {
        START_OFF,
        START_RUN,
        START_BLOCKED
    } start_state_e;

endpackage : cmd_word_pkg

/* hw/fieldbus_command_word_decoder.sv */
// fieldbus command word decoder for the grid converter
`timescale 1ns/10ps
`default_nettype none

`include "cmd_word_consts.svh"

// Functional notes
// - start bit low stops a running unit or abandons an unfinished startup
// - start bit high begins startup sequence or keeps the unit running
// - pre-charge starts only on a rising edge of the start bit
// - edge start mode: an edge that cannot be honoured is discarded; precharge_trigger still pulses on it
// - application pre-charge control follows bit 4 level
// - bit 4 ignored when pre-charge is not application controlled
// - each rising edge of bit 7 issues one event clear pulse
// - valid bit low freezes the last word processed while valid was high
// - on Modbus the valid bit qualifies only the command word
// - watchdog bit always comes from the current incoming word
// - default word 0x5 initially and while watchdog fault is active
// - master drives bit 11 as watchdog, fed to watchdog supervision
// - bits 12 to 15 drive auxiliary virtual slots, active when one
// - operation needs switch-on permission and start; dropping permission stops
// - bit 2 low requests quick stop, halting modulation
module fieldbus_command_word_decoder
    import cmd_word_pkg::*;
#(
    parameter int WIDTH    = `CMD_WORD_WIDTH,
    parameter int AUX_BITS = 4
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                pd_update,
    input  wire logic [WIDTH-1:0]    incoming_command_word,
    input  wire logic [WIDTH-1:0]    proc_value_in,
    input  wire logic                modbus_link,
    input  wire logic                watchdog_fault,
    input  wire logic                edge_start_mode,
    input  wire logic                precharge_app_ctrl,
    input  wire logic                start_possible,
    input  wire logic                unit_running,
    output logic      [WIDTH-1:0]    effective_word,
    output logic      [WIDTH-1:0]    proc_value_out,
    output logic                     watchdog_bit,
    output logic                     run_request,
    output logic                     stop_request,
    output logic                     precharge_trigger,
    output logic                     precharge_enable,
    output logic                     main_breaker_enable,
    output logic                     quick_stop,
    output logic                     event_clear,
    output logic      [AUX_BITS-1:0] aux_slot
);

    // ========================================================
    // elaboration checks
    if (WIDTH != `CMD_WORD_WIDTH) begin : g_bad_width
        $error("decoder: WIDTH must be 16");
    end
    if (AUX_BITS != `CMD_AUX_MSB - `CMD_AUX_LSB + 1) begin : g_bad_aux
        $error("decoder: AUX_BITS must be 4");
    end

    // ========================================================
    // internal signals
    logic [WIDTH-1:0] held_word;
    logic [WIDTH-1:0] next_effective;
    logic [WIDTH-1:0] rise;
    logic             eff_sample;
    logic             upd_d1;
    start_state_e     start_state;
    start_state_e     next_start_state;
    logic             permit;
    logic             start_level;
    logic             start_rise;

    // bit picker shared by the decode below
    function automatic logic cmd_bit(input logic [WIDTH-1:0] w, input int pos);
        cmd_bit = w[pos];
    endfunction : cmd_bit

    // ========================================================
    // input qualification
    // held word starts at the default and only follows valid words
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            held_word <= `CMD_DEFAULT_WORD;
        end else if (pd_update && cmd_bit(incoming_command_word, `CMD_BIT_VALID)) begin
            held_word <= incoming_command_word;
        end
    end

    // other process values: modbus bypasses the valid gate
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            proc_value_out <= '0;
        end else if (pd_update &&
                     (modbus_link || cmd_bit(incoming_command_word, `CMD_BIT_VALID))) begin
            proc_value_out <= proc_value_in;
        end
    end

    // watchdog taken from every incoming word, valid or not
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            watchdog_bit <= 1'b0;
        end else if (pd_update) begin
            watchdog_bit <= cmd_bit(incoming_command_word, `CMD_BIT_WATCHDOG);
        end
    end

    // effective word: default while the watchdog fault is active
    always_comb begin
        next_effective = watchdog_fault ? `CMD_DEFAULT_WORD : held_word;
        next_effective = next_effective & `CMD_USED_MASK;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            effective_word <= `CMD_DEFAULT_WORD;
        end else begin
            effective_word <= next_effective;
        end
    end

    // strobe marking that effective_word reflects a fresh update
    // two stages: held_word then effective_word, so the edge compare sees the new word
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            upd_d1     <= 1'b0;
            eff_sample <= 1'b0;
        end else begin
            upd_d1     <= pd_update;
            eff_sample <= upd_d1;
        end
    end

    // ========================================================
    // edge detection between successive effective words
    cmd_edge_detect #(
        .WIDTH      (WIDTH)
    ) u_edge (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .sample     (eff_sample),
        .word       (effective_word),
        .reset_word (`CMD_DEFAULT_WORD),
        .rise       (rise)
    );

    assign permit      = cmd_bit(effective_word, `CMD_BIT_SWITCH_ON);
    assign start_level = cmd_bit(effective_word, `CMD_BIT_START);
    assign start_rise  = cmd_bit(rise, `CMD_BIT_START);

    // ========================================================
    // start sequencing
    always_comb begin
        next_start_state = start_state;
        case (start_state)
            START_OFF: begin
                if (edge_start_mode) begin
                    if (start_rise && permit) begin
                        // an edge that cannot be served is dropped
                        next_start_state = start_possible ? START_RUN
                                                          : START_BLOCKED;
                    end
                end else if (start_level && permit) begin
                    next_start_state = START_RUN;
                end
            end
            START_RUN: begin
                if (!start_level || !permit) begin
                    next_start_state = START_OFF;
                end
            end
            START_BLOCKED: begin
                // wait for start low so a fresh edge is needed
                if (!start_level) begin
                    next_start_state = START_OFF;
                end
            end
            default: begin
                next_start_state = START_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_state <= START_OFF;
        end else begin
            start_state <= next_start_state;
        end
    end

    // run and stop requests toward the sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_request  <= 1'b0;
            stop_request <= 1'b0;
        end else begin
            run_request  <= (next_start_state == START_RUN);
            stop_request <= (next_start_state != START_RUN) && unit_running;
        end
    end

    // ========================================================
    // pre-charge control
    // pre-charge kicked off only by a start edge under permission
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            precharge_trigger <= 1'b0;
        end else begin
            precharge_trigger <= start_rise && permit;
        end
    end

    // application-held pre-charge level, ignored otherwise
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            precharge_enable <= 1'b0;
        end else begin
            precharge_enable <= precharge_app_ctrl && permit &&
                                cmd_bit(effective_word, `CMD_BIT_PRECHARGE);
        end
    end

    // ========================================================
    // level decodes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            main_breaker_enable <= 1'b0;
            quick_stop          <= 1'b0;
            aux_slot            <= '0;
        end else begin
            main_breaker_enable <= permit && cmd_bit(effective_word, `CMD_BIT_BREAKER_EN);
            quick_stop          <= !cmd_bit(effective_word, `CMD_BIT_QUICK_STOP);
            aux_slot            <= effective_word[`CMD_AUX_MSB:`CMD_AUX_LSB];
        end
    end

    // ========================================================
    // event clear: one pulse per rising edge of the reset bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            event_clear <= 1'b0;
        end else begin
            event_clear <= cmd_bit(rise, `CMD_BIT_EVENT_CLEAR);
        end
    end

endmodule : fieldbus_command_word_decoder

`default_nettype wire

/* testbench/cmd_decoder_chk.sv */
// assertion checker for the command word decoder
`timescale 1ns/10ps
`default_nettype none
`include "cmd_word_consts.svh"
module cmd_decoder_chk #(
    parameter int WIDTH    = 16,
    parameter int AUX_BITS = 4
) (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                pd_update,
    input wire logic [WIDTH-1:0]    incoming_command_word,
    input wire logic                watchdog_fault,
    input wire logic [WIDTH-1:0]    effective_word,
    input wire logic                watchdog_bit,
    input wire logic                run_request,
    input wire logic                precharge_trigger,
    input wire logic                quick_stop,
    input wire logic                event_clear,
    input wire logic [AUX_BITS-1:0] aux_slot
);
    // ========================================
    // sampling defaults and update sequences
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence valid_upd;
        pd_update && incoming_command_word[10] && !watchdog_fault
        ##1 !pd_update && !watchdog_fault;
    endsequence
    sequence invalid_upd;
        !pd_update ##1 pd_update && !incoming_command_word[10] && !watchdog_fault
        ##1 !pd_update && !watchdog_fault;
    endsequence
    // lone update with no fault around it, so edges are seen per update only
    sequence quiet_upd;
        pd_update && !watchdog_fault ##1 !pd_update && !watchdog_fault
        ##1 !pd_update && !watchdog_fault;
    endsequence
    // ========================================
    // word qualification
    valid_load_a: assert property (valid_upd |=>
        effective_word == ($past(incoming_command_word, 2) & `CMD_USED_MASK))
        else $error("valid word not taken");
    frozen_word_a: assert property (invalid_upd |=> $stable(effective_word))
        else $error("invalid word not ignored");
    fault_default_a: assert property (watchdog_fault |=>
        effective_word == `CMD_DEFAULT_WORD) else $error("default word missing");
    wd_follow_a: assert property (pd_update |=>
        watchdog_bit == $past(incoming_command_word[11])) else $error("watchdog bit wrong");
    // ========================================
    // decoded controls and events
    clear_edge_a: assert property (quiet_upd ##0 $rose(effective_word[7])
        |-> ##2 event_clear) else $error("clear pulse missing");
    clear_pulse_a: assert property (event_clear |=> !event_clear)
        else $error("clear pulse too long");
    trigger_edge_a: assert property (quiet_upd ##0
        ($rose(effective_word[3]) && effective_word[0]) |-> ##2 precharge_trigger)
        else $error("trigger missing");
    start_drop_a: assert property ($fell(effective_word[3]) || $fell(effective_word[0])
        |-> ##2 !run_request) else $error("run not dropped");
    quick_stop_a: assert property (quick_stop == !$past(effective_word[2]))
        else $error("quick stop wrong");
    aux_slot_a: assert property (aux_slot == $past(effective_word[15:12]))
        else $error("aux slots wrong");
endmodule : cmd_decoder_chk
bind fieldbus_command_word_decoder cmd_decoder_chk #(
    .WIDTH    (WIDTH),
    .AUX_BITS (AUX_BITS)
) i_chk (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .pd_update             (pd_update),
    .incoming_command_word (incoming_command_word),
    .watchdog_fault        (watchdog_fault),
    .effective_word        (effective_word),
    .watchdog_bit          (watchdog_bit),
    .run_request           (run_request),
    .precharge_trigger     (precharge_trigger),
    .quick_stop            (quick_stop),
    .event_clear           (event_clear),
    .aux_slot              (aux_slot)
);
`default_nettype wire

/* testbench/fb_master_model.sv */
// fieldbus master model sending command and process words
`timescale 1ns/10ps
`default_nettype none
module fb_master_model (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        go,
    input  wire logic [15:0] word,
    input  wire logic [15:0] proc,
    output logic             pd_update,
    output logic      [15:0] cmd_word,
    output logic      [15:0] proc_val
);
    logic wd;
    // one frame per go, lines scrambled between frames
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pd_update <= 1'b0;
            wd        <= 1'b0;
            cmd_word  <= 16'h0000;
            proc_val  <= 16'h0000;
        end else if (go) begin
            pd_update <= 1'b1;
            wd        <= ~wd;
            cmd_word  <= {word[15:12], ~wd, word[10:0]};
            proc_val  <= proc;
        end else begin
            pd_update <= 1'b0;
            cmd_word  <= ~cmd_word;
            proc_val  <= ~proc_val;
        end
    end
endmodule : fb_master_model
`default_nettype wire

/* testbench/fieldbus_command_word_decoder_tb.sv */
// self-checking bench for the command word decoder
`timescale 1ns/10ps
`default_nettype none
`include "cmd_word_consts.svh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module fieldbus_command_word_decoder_tb;
    logic        clk, sys_rst, go, modbus_link, watchdog_fault, edge_start_mode;
    logic        precharge_app_ctrl, start_possible, unit_running, pd_update, wd_exp;
    logic        watchdog_bit, run_request, stop_request, precharge_trigger, precharge_enable;
    logic        main_breaker_enable, quick_stop, event_clear;
    logic [15:0] word, proc, incoming_command_word, proc_value_in, effective_word;
    logic [15:0] proc_value_out, held, pv_exp, last, sent;
    logic [3:0]  aux_slot;
    int          n_fail, checks_done, n_clr, n_trg, exp_clr, exp_trg, r;
    fb_master_model i_master (.clk(clk), .sys_rst(sys_rst), .go(go), .word(word), .proc(proc),
        .pd_update(pd_update), .cmd_word(incoming_command_word), .proc_val(proc_value_in));
    fieldbus_command_word_decoder i_dut (.clk(clk), .sys_rst(sys_rst), .pd_update(pd_update),
        .incoming_command_word(incoming_command_word), .proc_value_in(proc_value_in),
        .modbus_link(modbus_link), .watchdog_fault(watchdog_fault),
        .edge_start_mode(edge_start_mode), .precharge_app_ctrl(precharge_app_ctrl),
        .start_possible(start_possible), .unit_running(unit_running),
        .effective_word(effective_word), .proc_value_out(proc_value_out),
        .watchdog_bit(watchdog_bit), .run_request(run_request), .stop_request(stop_request),
        .precharge_trigger(precharge_trigger), .precharge_enable(precharge_enable),
        .main_breaker_enable(main_breaker_enable), .quick_stop(quick_stop),
        .event_clear(event_clear), .aux_slot(aux_slot));
    // ========================================
    // clock, pulse counters and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (event_clear === 1'b1) n_clr++;
        if (precharge_trigger === 1'b1) n_trg++;
    end
    initial begin
        repeat (4000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    // ========================================
    // one frame through the master, then common checks
    task automatic send(input logic [15:0] w, input logic [15:0] p);
        @(posedge clk);
        go   <= 1'b1;
        word <= w;
        proc <= p;
        @(posedge clk);
        go <= 1'b0;
        wd_exp = ~wd_exp;
        sent = {w[15:12], wd_exp, w[10:0]};
        if (sent[10]) held = sent & `CMD_USED_MASK;
        if (sent[10] || modbus_link) pv_exp = p;
        if (held[7] && !last[7]) exp_clr++;
        if (held[3] && !last[3] && held[0]) exp_trg++;
        last = held;
        repeat (6) @(posedge clk);
        #1;
        `CHK("effective", held, effective_word)
        `CHK("watchdog", wd_exp, watchdog_bit)
        `CHK("process", pv_exp, proc_value_out)
        `CHK("aux", held[15:12], aux_slot)
        `CHK("quick stop", ~held[2], quick_stop)
        `CHK("breaker", held[0] & held[1], main_breaker_enable)
    endtask : send
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    // ========================================
    // test sequence
    initial begin
        {sys_rst, go, modbus_link, watchdog_fault, edge_start_mode} = 5'b10000;
        {precharge_app_ctrl, start_possible, unit_running, wd_exp} = 4'b0100;
        {word, proc, held, last, pv_exp} = {16'h0000, 16'h0000, 16'h0005, 16'h0005, 16'h0000};
        {n_fail, checks_done, n_clr, n_trg, exp_clr, exp_trg} = '0;
        r = $urandom(32'h666FFF44);
        repeat (5) @(posedge clk);
        `CHK("reset word", 16'h0005, effective_word)
        sys_rst <= 1'b0;
        @(posedge clk);
        send(16'h048D, 16'h1234);
        `CHK("level run", 1'b1, run_request)
        send(16'h0365, 16'hABCD);
        send(16'h0765, 16'h0F0F);
        $display("corner words done");
        for (int i = 0; i < 2; i++) begin
            precharge_app_ctrl <= i[0];
            send(16'h0415, 16'h0000);
            `CHK("precharge on", i[0], precharge_enable)
            send(16'h0405, 16'h0000);
            `CHK("precharge off", 1'b0, precharge_enable)
        end
        $display("precharge done");
        send(16'hA405, 16'h0000);
        watchdog_fault <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK("fault word", 16'h0005, effective_word)
        watchdog_fault <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK("restored word", held, effective_word)
        $display("fault default done");
        edge_start_mode <= 1'b1;
        start_possible  <= 1'b0;
        send(16'h0409, 16'h0000);
        start_possible <= 1'b1;
        send(16'h0409, 16'h0000);
        `CHK("refused edge", 1'b0, run_request)
        send(16'h0401, 16'h0000);
        send(16'h0409, 16'h0000);
        `CHK("fresh edge", 1'b1, run_request)
        unit_running <= 1'b1;
        send(16'h0401, 16'h0000);
        `CHK("stopped", 1'b0, run_request)
        `CHK("stop request", 1'b1, stop_request)
        unit_running    <= 1'b0;
        edge_start_mode <= 1'b0;
        $display("edge start done");
        for (int i = 0; i < 40; i++) begin
            modbus_link <= 1'($urandom_range(0, 1));
            send(16'($urandom), 16'($urandom));
            `CHK("random run", held[0] & held[3], run_request)
        end
        `CHK("clear pulses", exp_clr, n_clr)
        `CHK("trigger pulses", exp_trg, n_trg)
        $display("random words done");
        complete_run();
    end
endmodule : fieldbus_command_word_decoder_tb
`default_nettype wire
